/* hdl/tmb_pkg.sv */
package tmb_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] ADDR_CNT_LO = 4'h0; // count_low_byte
    localparam logic [3:0] ADDR_CNT_HI = 4'h1; // count_high_byte
    localparam logic [3:0] ADDR_CCP_LO = 4'h2; // capcomp_low_byte
    localparam logic [3:0] ADDR_CCP_HI = 4'h3; // capcomp_high_byte
    localparam logic [3:0] ADDR_CTRL = 4'h4; // timer_control_reg
    localparam logic [3:0] ADDR_GATE = 4'h5; // gate control and status
    localparam logic [3:0] ADDR_FLAG = 4'h6; // peripheral_flag_reg
    localparam logic [3:0] ADDR_PIE = 4'h7; // peripheral_enable_reg
    localparam logic [3:0] ADDR_INTC = 4'h8; // interrupt_control_reg
    localparam logic [3:0] ADDR_MODE = 4'h9; // capture/compare mode

    // field positions
    localparam int CTRL_CS_HI = 7;
    localparam int CTRL_CS_LO = 6;
    localparam int CTRL_SYNC_BIT = 2;
    localparam int CTRL_ON_BIT = 0;
    localparam int GATE_SPM_BIT = 4;
    localparam int GATE_GO_BIT = 3;
    localparam int GATE_VAL_BIT = 2;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_GATE_BIT = 7;
    localparam int INTC_GIE_BIT = 7;
    localparam int INTC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;

    // counter limits and instruction clock divider
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [1:0] INSTR_DIV_ONE = 2'h1;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // sampled input lanes of the edge detector
    localparam int EDGE_EXT_RAW = 0;
    localparam int EDGE_EXT_SYNC = 1;
    localparam int EDGE_LFOSC = 2;
    localparam int EDGE_GATE = 3;
    localparam int EDGE_N = 4;

    typedef enum logic [1:0] {
        CS_INSTR = 2'h0,
        CS_SYS = 2'h1,
        CS_EXT = 2'h2,
        CS_LFOSC = 2'h3
    } tmb_clk_src_t;

    typedef enum logic [1:0] {
        CCP_OFF = 2'h0,
        CCP_CAPTURE = 2'h1,
        CCP_COMPARE = 2'h2,
        CCP_COMPARE_TRIG = 2'h3
    } tmb_ccp_mode_t;

    typedef struct packed {
        tmb_clk_src_t src;
        logic sync_disable;
        logic timer_on;
    } tmb_ctrl_t;

    typedef struct packed {
        logic gate_single_pulse_enable;
        logic single_pulse_go_done;
    } tmb_gate_t;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic overflow_irq_enable;
        logic gate_irq_enable;
    } tmb_irq_en_t;

    typedef struct packed {
        logic overflow_flag;
        logic gate_event_flag;
    } tmb_flags_t;

    localparam tmb_ctrl_t CTRL_RST = '{src: CS_INSTR, sync_disable: 1'b0, timer_on: 1'b0};
    localparam tmb_gate_t GATE_RST = '{1'b0, 1'b0};
    localparam tmb_irq_en_t IRQ_EN_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
    localparam tmb_flags_t FLAGS_RST = '{1'b0, 1'b0};

endpackage

/* hdl/tmb_sync2.sv */
`timescale 1ns/1ns
`default_nettype none

// two flop synchroniser for a free running level
module tmb_sync2
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);

    logic meta;

    // meta feeds only the second flop
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule
`default_nettype wire

/* hdl/tmb_edge.sv */
`timescale 1ns/1ns
`default_nettype none

// per lane rising and falling edge detect against the last sample
module tmb_edge
#(
    parameter int W = 1
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] in_i,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    logic [W-1:0] prev;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            prev <= '0;
        else
            prev <= in_i;
    end

    // edges are seen in the same cycle the new level arrives
    assign rise_o = in_i & ~prev;
    assign fall_o = ~in_i & prev;

endmodule
`default_nettype wire

/* hdl/tmb_timebase.sv */
// How it works
// R1 - count runs up to ffff, wraps to 0000 and sets the overflow flag
// R2 - overflow interrupt only with timer on and overflow, peripheral, global enables set
// R3 - software clears the overflow flag; hardware never does
// R4 - software should zero count and flag before enabling interrupts
// R5 - in sleep, count only unsynchronised from external or low power source
// R6 - sleep overflow wakes when on, enables set, unsynchronised, proper source
// R7 - wake resumes code; service routine only when global enable is set
// R8 - secondary oscillator keeps running in sleep regardless of sync setting
// R9 - capture event copies the count into the capture/compare pair
// R10 - compare mode raises an event when count equals the pair
// R11 - conversion trigger from compare clears the count, pair acts as period
// R12 - trigger clear never sets the overflow flag
// R13 - software should use synchronised instruction clock with the trigger
// R14 - a count byte write in the trigger cycle wins over the clear
// R15 - single pulse go/done cleared by hardware on gate value falling edge
// R16 - gate event flag set on gate value falling edge, held until cleared
// R17 - source code 11 low power, 10 external, 01 system, 00 instruction
// R18 - sync disable one runs external clock raw, zero synchronises it
// R19 - single pulse mode blocks counting once go/done clears until set again
// R20 - counting continues after wrap; flag stays set until software clears
// R21 - flag is writable; a new overflow wins over a software clear
`timescale 1ns/1ns
`default_nettype none

module tmb_timebase
import tmb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic sleep_i,
    input wire logic ext_clk_i,
    input wire logic lfosc_i,
    input wire logic gate_i,
    input wire logic capture_event_i,
    output logic irq_o,
    output logic wake_o,
    output logic compare_event_o,
    output logic adc_trigger_o,
    output logic sec_osc_run_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    tmb_ctrl_t ctrl, next_ctrl;
    tmb_gate_t gate, next_gate;
    tmb_irq_en_t irq_en, next_irq_en;
    tmb_flags_t flags, next_flags;
    tmb_ccp_mode_t mode, next_mode;
    logic [15:0] count, next_count;
    logic [15:0] ccp, next_ccp;
    logic [1:0] instr_div, next_instr_div;
    logic match_q, next_match_q;
    logic [DATA_W-1:0] next_rdata;
    logic next_irq, next_wake, next_cmp, next_trig;

    // decoded terms
    logic ext_sync;
    logic [EDGE_N-1:0] edge_in, rise, fall;
    logic src_tick, async_src, sleep_ok, gate_ok, inc, wrap, match;
    logic wr_cnt, wr_lo, wr_hi;

    ////////////////////////////////////////////////////////////////////////////////
    // input conditioning
    tmb_sync2 u_ext_sync
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(ext_clk_i),
        .q_o(ext_sync)
    );

    assign edge_in = {gate_i, lfosc_i, ext_sync, ext_clk_i};

    tmb_edge #(.W(EDGE_N)) u_edge
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_i(edge_in),
        .rise_o(rise),
        .fall_o(fall)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // increment qualification
    always_comb
    begin
        unique case (ctrl.src) // [R17]
            CS_INSTR: src_tick = (instr_div == INSTR_DIV_LAST);
            CS_SYS: src_tick = 1'b1;
            // raw edge when unsynchronised, two flops later otherwise
            CS_EXT: src_tick = ctrl.sync_disable ? rise[EDGE_EXT_RAW] : rise[EDGE_EXT_SYNC]; // [R18]
            CS_LFOSC: src_tick = rise[EDGE_LFOSC];
        endcase
        async_src = ctrl.sync_disable && (ctrl.src == CS_EXT || ctrl.src == CS_LFOSC);
        sleep_ok = !sleep_i || async_src; // [R5]
        // single pulse: only while armed and gate value high
        gate_ok = !gate.gate_single_pulse_enable
            || (gate.single_pulse_go_done && gate_i); // [R19]
        inc = ctrl.timer_on && src_tick && sleep_ok && gate_ok;
    end

    assign wr_lo = wr_i && (addr_i == ADDR_CNT_LO);
    assign wr_hi = wr_i && (addr_i == ADDR_CNT_HI);
    assign wr_cnt = wr_lo || wr_hi;
    assign match = (mode == CCP_COMPARE || mode == CCP_COMPARE_TRIG) && (count == ccp);

    ////////////////////////////////////////////////////////////////////////////////
    // next state: counter, flags, registers
    always_comb
    begin
        next_ctrl = ctrl;
        next_gate = gate;
        next_irq_en = irq_en;
        next_flags = flags;
        next_mode = mode;
        next_ccp = ccp;
        next_instr_div = instr_div + INSTR_DIV_ONE;
        next_match_q = match;

        // counter keeps running past the wrap
        next_count = inc ? count + CNT_ONE : count; // [R1] [R20]
        // a wrap only counts when the increment actually lands
        wrap = inc && (count == CNT_MAX) && !adc_trigger_o && !wr_cnt;
        // trigger clear is not an overflow
        if (adc_trigger_o)
            next_count = CNT_ZERO; // [R11] [R12]
        // software byte write overrides both increment and trigger clear
        if (wr_lo)
            next_count[7:0] = wdata_i; // [R14]
        if (wr_hi)
            next_count[15:8] = wdata_i; // [R14]

        // software register writes
        if (wr_i)
        begin
            unique case (addr_i)
                ADDR_CCP_LO: next_ccp[7:0] = wdata_i;
                ADDR_CCP_HI: next_ccp[15:8] = wdata_i;
                ADDR_CTRL:
                begin
                    next_ctrl.src = tmb_clk_src_t'(wdata_i[CTRL_CS_HI:CTRL_CS_LO]);
                    next_ctrl.sync_disable = wdata_i[CTRL_SYNC_BIT];
                    next_ctrl.timer_on = wdata_i[CTRL_ON_BIT];
                end
                ADDR_FLAG:
                begin
                    next_flags.overflow_flag = wdata_i[FLAG_OVF_BIT]; // [R21]
                    next_flags.gate_event_flag = wdata_i[FLAG_GATE_BIT];
                end
                ADDR_PIE:
                begin
                    next_irq_en.overflow_irq_enable = wdata_i[FLAG_OVF_BIT];
                    next_irq_en.gate_irq_enable = wdata_i[FLAG_GATE_BIT];
                end
                ADDR_INTC:
                begin
                    next_irq_en.global_irq_enable = wdata_i[INTC_GIE_BIT];
                    next_irq_en.peripheral_irq_enable = wdata_i[INTC_PERIPHERAL_IRQ_ENABLE_BIT];
                end
                ADDR_MODE: next_mode = tmb_ccp_mode_t'(wdata_i[MODE_HI:MODE_LO]);
                default: ;
            endcase
        end

        // hardware clears go/done on the trailing gate edge; a write wins
        if (gate.gate_single_pulse_enable && fall[EDGE_GATE])
            next_gate.single_pulse_go_done = 1'b0; // [R15]
        if (wr_i && addr_i == ADDR_GATE)
        begin
            next_gate.gate_single_pulse_enable = wdata_i[GATE_SPM_BIT];
            next_gate.single_pulse_go_done = wdata_i[GATE_GO_BIT];
        end

        // hardware sets win over software clears; only software clears
        if (wrap)
            next_flags.overflow_flag = 1'b1; // [R1] [R21] [R3]
        if (fall[EDGE_GATE])
            next_flags.gate_event_flag = 1'b1; // [R16]

        // capture snapshot outranks a software write of the pair
        if (mode == CCP_CAPTURE && capture_event_i)
            next_ccp = count; // [R9]

        // one compare pulse per arrival at the match value
        next_cmp = match && !match_q; // [R10]
        next_trig = next_cmp && (mode == CCP_COMPARE_TRIG); // [R11]

        // interrupt needs the whole enable chain including global
        next_irq = (irq_en.global_irq_enable && irq_en.peripheral_irq_enable)
            && ((flags.overflow_flag && irq_en.overflow_irq_enable && ctrl.timer_on)
            || (flags.gate_event_flag && irq_en.gate_irq_enable)); // [R2] [R7]
        // wake ignores the global enable so the core just resumes
        next_wake = sleep_i && flags.overflow_flag && irq_en.overflow_irq_enable
            && irq_en.peripheral_irq_enable && ctrl.timer_on && async_src; // [R6] [R7]

        // read data stands only in the cycle after the strobe
        next_rdata = RD_ZERO;
        if (rd_i)
        begin
            unique case (addr_i)
                ADDR_CNT_LO: next_rdata = count[7:0];
                ADDR_CNT_HI: next_rdata = count[15:8];
                ADDR_CCP_LO: next_rdata = ccp[7:0];
                ADDR_CCP_HI: next_rdata = ccp[15:8];
                ADDR_CTRL:
                begin
                    next_rdata[CTRL_CS_HI:CTRL_CS_LO] = ctrl.src;
                    next_rdata[CTRL_SYNC_BIT] = ctrl.sync_disable;
                    next_rdata[CTRL_ON_BIT] = ctrl.timer_on;
                end
                ADDR_GATE:
                begin
                    next_rdata[GATE_SPM_BIT] = gate.gate_single_pulse_enable;
                    next_rdata[GATE_GO_BIT] = gate.single_pulse_go_done;
                    next_rdata[GATE_VAL_BIT] = gate_i;
                end
                ADDR_FLAG:
                begin
                    next_rdata[FLAG_OVF_BIT] = flags.overflow_flag;
                    next_rdata[FLAG_GATE_BIT] = flags.gate_event_flag;
                end
                ADDR_PIE:
                begin
                    next_rdata[FLAG_OVF_BIT] = irq_en.overflow_irq_enable;
                    next_rdata[FLAG_GATE_BIT] = irq_en.gate_irq_enable;
                end
                ADDR_INTC:
                begin
                    next_rdata[INTC_GIE_BIT] = irq_en.global_irq_enable;
                    next_rdata[INTC_PERIPHERAL_IRQ_ENABLE_BIT] = irq_en.peripheral_irq_enable;
                end
                ADDR_MODE: next_rdata[MODE_HI:MODE_LO] = mode;
                default: next_rdata = RD_ZERO; // unmapped reads as zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= CTRL_RST;
            gate <= GATE_RST;
            irq_en <= IRQ_EN_RST;
            flags <= FLAGS_RST;
            mode <= CCP_OFF;
            count <= CNT_ZERO;
            ccp <= CNT_ZERO;
            instr_div <= 2'h0;
            match_q <= 1'b0;
            rdata_o <= RD_ZERO;
            irq_o <= 1'b0;
            wake_o <= 1'b0;
            compare_event_o <= 1'b0;
            adc_trigger_o <= 1'b0;
            sec_osc_run_o <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            gate <= next_gate;
            irq_en <= next_irq_en;
            flags <= next_flags;
            mode <= next_mode;
            count <= next_count;
            ccp <= next_ccp;
            instr_div <= next_instr_div;
            match_q <= next_match_q;
            rdata_o <= next_rdata;
            irq_o <= next_irq;
            wake_o <= next_wake;
            compare_event_o <= next_cmp;
            adc_trigger_o <= next_trig;
            // oscillator enable is not gated by sleep or sync setting
            sec_osc_run_o <= 1'b1; // [R8]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wrap;
        inc && count == CNT_MAX && !adc_trigger_o && !wr_cnt;
    endsequence
    property p_wrap_sets_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_wrap |=> count == CNT_ZERO && flags.overflow_flag;
    endproperty
    a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap lost"); // [R1]

    property p_irq_enables;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        irq_o && !$past(flags.gate_event_flag) |->
            $past(irq_en.global_irq_enable && irq_en.peripheral_irq_enable
            && irq_en.overflow_irq_enable && ctrl.timer_on);
    endproperty
    a_irq_enables: assert property (p_irq_enables) else $error("irq without enables"); // [R2]

    property p_sleep_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        sleep_i && !async_src && !wr_cnt && !adc_trigger_o |=> count == $past(count);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep"); // [R5]

    property p_wake;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        sleep_i && flags.overflow_flag && irq_en.overflow_irq_enable
            && irq_en.peripheral_irq_enable && ctrl.timer_on && async_src |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake"); // [R6]

    sequence s_gie_off;
        !irq_en.global_irq_enable ##1 !irq_en.global_irq_enable;
    endsequence
    property p_no_isr_without_gie;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_gie_off |-> !irq_o;
    endproperty
    a_no_isr_without_gie: assert property (p_no_isr_without_gie) else $error("irq no gie"); // [R7]

    property p_capture;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        mode == CCP_CAPTURE && capture_event_i |=> ccp == $past(count);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed"); // [R9]

    property p_compare;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        match && !match_q |=> compare_event_o;
    endproperty
    a_compare: assert property (p_compare) else $error("compare missed"); // [R10]

    property p_trig_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        adc_trigger_o && !wr_cnt |=> count == CNT_ZERO;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger no clear"); // [R11]

    property p_trig_no_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        adc_trigger_o && !flags.overflow_flag && !wr_i |=> !flags.overflow_flag;
    endproperty
    a_trig_no_flag: assert property (p_trig_no_flag) else $error("trigger set flag"); // [R12]

    property p_write_wins;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        adc_trigger_o && wr_lo |=> count[7:0] == $past(wdata_i);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("write lost"); // [R14]

    property p_go_done_clear;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        gate.gate_single_pulse_enable && fall[EDGE_GATE] && !wr_i |=> !gate.single_pulse_go_done;
    endproperty
    a_go_done_clear: assert property (p_go_done_clear) else $error("go not cleared"); // [R15]

    property p_gate_flag;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        fall[EDGE_GATE] |=> flags.gate_event_flag;
    endproperty
    a_gate_flag: assert property (p_gate_flag) else $error("gate flag missed"); // [R16]

    property p_sys_clk_count;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ctrl.src == CS_SYS && ctrl.timer_on && !sleep_i && !gate.gate_single_pulse_enable
            && !wr_cnt && !adc_trigger_o |=> count == $past(count) + CNT_ONE;
    endproperty
    a_sys_clk_count: assert property (p_sys_clk_count) else $error("no sys count"); // [R17]

    property p_pulse_blocked;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        gate.gate_single_pulse_enable && !gate.single_pulse_go_done && !wr_cnt
            && !adc_trigger_o |=> count == $past(count);
    endproperty
    a_pulse_blocked: assert property (p_pulse_blocked) else $error("counted unarmed"); // [R19]

endmodule
`default_nettype wire

/* verification/tmb_far_model.sv */
`timescale 1ns/1ns
`default_nettype none

// far side: external clock pin, low power oscillator, gate pin, capture source
module tmb_far_model
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic cap_req_i,
    input wire logic gate_req_i,
    output logic ext_clk_o,
    output logic lfosc_o,
    output logic capture_o,
    output logic gate_o
);
    logic [2:0] div;

    // pin clock stands low outside a run so no stray rise slips in
    always_ff @(posedge core_clk_i)
    begin
        div <= rst_n_i ? div + 3'h1 : 3'h0;
        ext_clk_o <= run_i & div[2];
        lfosc_o <= div[1];
        capture_o <= cap_req_i;
        gate_o <= gate_req_i;
    end
endmodule

`default_nettype wire

/* verification/test_timer1_overflow_ccp_timebase.sv */
`timescale 1ns/1ns
`default_nettype none

module test_timer1_overflow_ccp_timebase
import tmb_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic run = 1'b0;
    logic cap_req = 1'b0;
    logic gate_req = 1'b0;
    logic [7:0] rdata;
    logic irq, wake, cmp, adc, sec, ext_clk, lfosc, cap, gate;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n_cmp = 0;
    int n_adc = 0;

    always #2 core_clk_i = ~core_clk_i;

    tmb_far_model far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .run_i(run),
        .cap_req_i(cap_req), .gate_req_i(gate_req), .ext_clk_o(ext_clk),
        .lfosc_o(lfosc), .capture_o(cap), .gate_o(gate));

    tmb_timebase DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sleep_i(sleep),
        .ext_clk_i(ext_clk), .lfosc_i(lfosc), .gate_i(gate), .capture_event_i(cap),
        .irq_o(irq), .wake_o(wake), .compare_event_o(cmp), .adc_trigger_o(adc),
        .sec_osc_run_o(sec));

    //////////////////////////////////////////////////////////////////////
    // cycle ceiling and pulse counters; pulses stand one cycle so count each edge
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cmp === 1'b1) n_cmp = n_cmp + 1;
        if (adc === 1'b1) n_adc = n_adc + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            conclude();
        end
    end

    task automatic conclude();
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    //////////////////////////////////////////////////////////////////////
    // bus master: strobe lands on the next edge, read data checked a cycle later
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        // data stands until this edge replaces it, so the old value is still seen here
        @(posedge core_clk_i);
        chk({8'h00, rdata & m}, {8'h00, e});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    //////////////////////////////////////////////////////////////////////
    task automatic t_gate();
        wr_reg(ADDR_GATE, 8'h18);
        gate_req <= 1'b1;
        idle(4);
        gate_req <= 1'b0;
        idle(5);
        rd_chk(ADDR_GATE, 8'h08, 8'h00);
        rd_chk(ADDR_FLAG, 8'h80, 8'h80);
        idle(5);
        rd_chk(ADDR_FLAG, 8'h80, 8'h80);
        wr_reg(ADDR_FLAG, 8'h00);
        // disarm single pulse, else an unarmed gate blocks all later counting
        wr_reg(ADDR_GATE, 8'h00);
    endtask

    // flag cleared before any enable goes on; count preset near the wrap on purpose
    task automatic t_overflow();
        wr_reg(ADDR_FLAG, 8'h00);
        wr_reg(ADDR_CNT_LO, 8'hfe);
        wr_reg(ADDR_CNT_HI, 8'hff);
        wr_reg(ADDR_PIE, 8'h01);
        wr_reg(ADDR_INTC, 8'h40);
        wr_reg(ADDR_CTRL, 8'h41);
        idle(10);
        chk({15'h0, irq}, 16'h0);
        // timer stays on: the interrupt needs it; the high byte stays 00 for 256 cycles
        rd_chk(ADDR_CNT_HI, 8'hff, 8'h00);
        rd_chk(ADDR_FLAG, 8'h01, 8'h01);
        wr_reg(ADDR_INTC, 8'hc0);
        idle(2);
        chk({15'h0, irq}, 16'h1);
        wr_reg(ADDR_FLAG, 8'h00); // software clears the flag itself
        idle(2);
        chk({15'h0, irq}, 16'h0);
        wr_reg(ADDR_INTC, 8'h00);
        wr_reg(ADDR_CTRL, 8'h00);
    endtask

    // timer stays off so equality comes only from the written count
    task automatic t_compare();
        logic [7:0] v;
        wr_reg(ADDR_CNT_HI, 8'h00);
        wr_reg(ADDR_CNT_LO, 8'h00);
        for (int m = 2; m < 4; m++)
        begin
            v = 8'h04 + 8'(m);
            // pair first, so the mode change never meets an old equality
            wr_reg(ADDR_CCP_LO, v);
            wr_reg(ADDR_MODE, 8'(m));
            n_cmp = 0;
            n_adc = 0;
            wr_reg(ADDR_CNT_LO, v);
            idle(4);
            chk(16'(n_cmp), 16'h1);
            chk(16'(n_adc), 16'(m == 3));
            rd_chk(ADDR_CNT_LO, 8'hff, (m == 3) ? 8'h00 : v);
            rd_chk(ADDR_FLAG, 8'h01, 8'h00);
        end
        // byte write lands on the very edge that the trigger clear would use
        wr_reg(ADDR_CNT_LO, 8'h07);
        idle(1);
        wr_reg(ADDR_CNT_HI, 8'h12);
        rd_chk(ADDR_CNT_HI, 8'hff, 8'h12);
    endtask

    task automatic t_capture();
        wr_reg(ADDR_MODE, 8'h01);
        wr_reg(ADDR_CNT_HI, 8'h00);
        wr_reg(ADDR_CNT_LO, 8'h34);
        cap_req <= 1'b1;
        idle(1);
        cap_req <= 1'b0;
        idle(3);
        rd_chk(ADDR_CCP_LO, 8'hff, 8'h34);
        rd_chk(ADDR_CCP_HI, 8'hff, 8'h00);
        wr_reg(ADDR_MODE, 8'h00);
    endtask

    task automatic t_sleep();
        int i;
        wr_reg(ADDR_CNT_LO, 8'hf8);
        wr_reg(ADDR_CNT_HI, 8'hff);
        wr_reg(ADDR_PIE, 8'h01);
        wr_reg(ADDR_INTC, 8'h40);
        sleep <= 1'b1;
        wr_reg(ADDR_CTRL, 8'h41);
        idle(10);
        rd_chk(ADDR_CNT_LO, 8'hff, 8'hf8);
        wr_reg(ADDR_CTRL, 8'h85);
        run <= 1'b1;
        for (i = 0; i < 200 && wake !== 1'b1; i++) idle(1);
        chk({15'h0, wake}, 16'h1);
        chk({15'h0, irq}, 16'h0);
        chk({15'h0, sec}, 16'h1);
        run <= 1'b0;
        sleep <= 1'b0;
        rd_chk(ADDR_FLAG, 8'h01, 8'h01);
    endtask

    //////////////////////////////////////////////////////////////////////
    initial
    begin
        idle(10);
        rst_n_i <= 1'b1;
        idle(1);
        rd_chk(ADDR_CTRL, 8'hff, 8'h00);
        rd_chk(4'hf, 8'hff, 8'h00);
        t_gate();
        t_overflow();
        t_compare();
        t_capture();
        t_sleep();
        conclude();
    end
endmodule

`default_nettype wire
